// [bench/flow_firmware_config_data_test.sv]
`timescale 1ns/1ps
module flow_firmware_config_data_test;
  import fw_config_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  fw_ctrl_t ctrl;
  fw_status_t status;
  int n_mismatch = 0;
  int cmp_count = 0;
  int k;
  int hits;
  logic [31:0] rd_d;
  logic [1:0] rsp;
  logic [31:0] pat [4] = '{32'h0, 32'h4155_9F2A, 32'hAEAA_A0D5, 32'hEFFF_BFFF};

  fw_config_bank #(.hour_period(20)) fw_config_bank_i (
    .mclk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ctrl, .status);

  initial begin
    forever #2 mclk = ~mclk;
  end

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= {a, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] a);
    @(posedge mclk);
    s_axi_araddr <= {a, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic gap();
    repeat (6) @(posedge mclk);
  endtask : gap

  function automatic fw_ctrl_t exp_ctrl(input logic [31:0] w);
    fw_ctrl_t e;
    e = '0;
    e.table_start = {1'b1, w[7:0]};
    e.table_exponent = w[13:8];
    e.piecewise_cal_enable = w[15];
    e.vendor_cal_enable = ~w[31];
    e.overflow_keep_value = w[16];
    e.zero_state_allowed = w[17] | (w[25:24] == 2'b00);
    e.iir_smoothing_enable = w[18];
    e.recall_enforce = ~w[19];
    e.pulse_flow_error = ~w[21];
    e.pulse_hw_error = ~w[21] & w[22];
    e.average_error_counters_on = w[23];
    e.threshold_regulation_method = threshold_method_t'(w[25:24]);
    e.threshold_as_ratio = w[26];
    e.sound_speed_limit_check = w[27];
    e.volume_triple_protect = w[29];
    e.cal_temperature_source = w[30];
    return e;
  endfunction : exp_ctrl

  task automatic test_done();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    test_done();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rd(10'h16A);
    chk("cfg reset", rd_d, 32'h0000_0102);
    chk("ctrl reset", ctrl.table_start, 9'h102);
    chk("rate err", status.rate_error, 1'b1);
    // Overflow, bad threshold and no-water inputs all raised
    wr(10'h181, 32'h0000_001C);
    for (k = 0; k < 4; k++) begin
      wr(10'h16A, pat[k]);
      gap();
      rd(10'h16A);
      chk("cfg", rd_d, pat[k]);
      chk("ctrl", ctrl, exp_ctrl(pat[k]));
    end
    wr(10'h16A, 32'h1000_0000);
    hits = 0;
    repeat (30) begin
      @(posedge mclk);
      hits += int'(status.recall_init_pulse);
    end
    chk("init pulses", hits, 1);
    rd(10'h16A);
    chk("recall init", rd_d, 32'h0010_0000);
    wr(10'h16B, 32'hABCD_7654);
    wr(10'h181, 32'h0000_0020);
    gap();
    chk("boot", status.boot_start, 1'b1);
    wr(10'h16B, 32'hABCD_7655);
    gap();
    chk("boot", status.boot_start, 1'b0);
    for (k = 0; k < 4; k++) begin
      wr(10'h181, 32'(k[1]));
      wr(10'h16C, (k == 3) ? 32'h0 : (32'h48DB_A399 ^ 32'(k == 1)));
      gap();
      chk("watchdog", status.watchdog_enable, k != 0);
      if (k > 1) chk("restore", status.config_restore, k == 2);
    end
    wr(10'h166, 32'h0);
    gap();
    chk("fast clk", status.fast_clock_hz, 32'h003D_0900);
    wr(10'h166, 32'h007A_1200);
    gap();
    chk("fast clk", status.fast_clock_hz, 32'h007A_1200);
    wr(10'h174, 32'h07AB_CDEF);
    gap();
    chk("rate", status.flight_time_rate, 8'h07);
    chk("rate err", status.rate_error, 1'b0);
    for (k = 0; k < 4; k++) begin
      wr(10'(10'h17C + k), 32'hC500_0000 + k);
      wr(10'(10'h182 + k), 32'hC500_0000 + k);
    end
    gap();
    chk("cs err", status.checksum_error, 1'b0);
    for (k = 0; k < 4; k++) begin
      wr(10'(10'h182 + k), 32'h0);
      gap();
      chk("cs err", status.checksum_error, 1'b1);
      wr(10'(10'h182 + k), 32'hC500_0000 + k);
    end
    wr(10'h181, 32'h0000_0016);
    wr(10'h16A, 32'h2000_0102);
    gap();
    chk("zero", status.flow_force_zero, 1'b1);
    chk("flow err", status.flow_error, 1'b1);
    chk("vol err", status.volume_error, 1'b1);
    wr(10'h16A, 32'h0001_0102);
    gap();
    chk("zero", status.flow_force_zero, 1'b0);
    chk("vol err", status.volume_error, 1'b0);
    hits = 0;
    repeat (100) begin
      @(posedge mclk);
      hits += int'(status.hourly_recall);
    end
    chk("recalls", hits, 5);
    chk("timer", status.force_hourly_timer, 1'b1);
    // Freeze just after a recall pulse has ended
    do begin
      @(posedge mclk);
    end while (status.hourly_recall !== 1'b1);
    ce <= 1'b0;
    hits = 0;
    repeat (40) begin
      @(posedge mclk);
      hits += int'(status.hourly_recall);
    end
    chk("frozen recalls", hits, 0);
    ce <= 1'b1;
    rd(10'h050);
    chk("unmapped rd", rsp, 2'b10);
    chk("unmapped data", rd_d, 32'h0);
    wr(10'h050, 32'h1);
    chk("unmapped wr", rsp, 2'b10);
    test_done();
  end
endmodule : flow_firmware_config_data_test

// [bench/fw_config_bank_checker.sv]
`timescale 1ns/1ps
module fw_config_bank_checker
  import fw_config_pkg::*;
#(
  parameter longint hour_period = fw_config_pkg::hour_cycles
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire fw_config_pkg::fw_ctrl_t ctrl,
  input wire fw_config_pkg::fw_status_t status
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Outputs valid from second edge
  // ----------------------------------------
  logic live_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      live_q <= 1'b0;
    end else begin
      live_q <= 1'b1;
    end
  end
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_TABLE_BIT8: assert property (live_q |-> ctrl.table_start[8])
    else $error("table start bit 8 clear");
  AST_FAST_CLK: assert property (live_q |-> status.fast_clock_hz != 32'h0000_0000)
    else $error("fast clock value zero");
  AST_RATE_ERR: assert property (live_q |->
    status.rate_error == (status.flight_time_rate == 8'h00))
    else $error("rate error mismatch");
  AST_PULSE_SUPP: assert property (ctrl.pulse_flow_error |-> status.flow_error)
    else $error("pulse error without flow error");
  AST_HOUR_PULSE: assert property (status.hourly_recall |=> !status.hourly_recall [*8])
    else $error("recall pulse too long");
  AST_FORCE_ZERO: assert property (status.flow_force_zero |->
    status.flow_error && !ctrl.overflow_keep_value)
    else $error("flow zeroed while keep set");
  AST_VOL_ERR: assert property (status.volume_error |-> ctrl.volume_triple_protect)
    else $error("volume error without protection");
  AST_WR_RESP: assert property (wr_taken |-> ##[1:4] s_axi_bvalid)
    else $error("write response missing");
  AST_RD_RESP: assert property (rd_taken |-> ##[1:3] s_axi_rvalid)
    else $error("read response missing");
endmodule : fw_config_bank_checker

bind fw_config_bank fw_config_bank_checker #(.hour_period(hour_period)) fw_config_bank_checker_i (
  .mclk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .ctrl, .status);

// [hw/fw_config_bank.sv]
`timescale 1ns/1ps
module fw_config_bank #(
  parameter longint hour_period = fw_config_pkg::hour_cycles
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output fw_config_pkg::fw_ctrl_t ctrl,
  output fw_config_pkg::fw_status_t status
);
  import fw_config_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [31:0] cfg_q, boot_q, wd_q, fclk_q, prc_q;
  logic [31:0] cs_q [4];
  logic [31:0] comp_q [4];
  logic [5:0] ctl_q;
  logic [5:0] ctl_s1_q, ctl_s2_q;
  logic start_q, hour_tick_w;
  logic [31:0] wr_mask;

  function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                             input logic [31:0] nv,
                                             input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = nv[i*8 +: 8];
    end
    return r;
  endfunction : apply_strb

  function automatic logic is_cs(input logic [11:0] a);
    return a >= addr_cs0 && a <= addr_cs3;
  endfunction : is_cs

  function automatic logic is_mapped(input logic [11:0] a);
    return a == addr_fw_config || a == addr_boot || a == addr_wd ||
      a == addr_fast_clk || a == addr_usm_prc || is_cs(a) ||
      a == addr_status || a == addr_control || (a >= addr_computed &&
      a < addr_computed + 12'd4);
  endfunction : is_mapped

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  logic aw_have_q, w_have_q;
  logic [11:0] aw_q;
  logic [31:0] wd_in_q;
  logic [3:0] ws_q;
  logic do_wr;
  logic [11:0] wa;
  logic [3:0] cidx;
  assign do_wr = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wa = aw_q >> 2;
  assign cidx = 4'(wa - addr_computed);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= '0;
      wd_in_q <= '0;
      ws_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (ce) begin
      s_axi_awready <= !aw_have_q && !s_axi_awready;
      s_axi_wready <= !w_have_q && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wd_in_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(wa) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Cells
  // ----------------------------------------
  logic recall_init;
  assign recall_init = status.hourly_recall && cfg_q[bit_init_req];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_q <= fw_config_reset;
    end else if (ce) begin
      if (do_wr && wa == addr_fw_config) begin
        cfg_q <= apply_strb(cfg_q, wd_in_q, ws_q);
      end else if (recall_init) begin
        cfg_q[bit_init_req] <= 1'b0; // R12
        cfg_q[bit_init_done] <= 1'b1; // R12
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      boot_q <= zero_word;
      wd_q <= zero_word;
      fclk_q <= zero_word;
      prc_q <= zero_word;
      ctl_q <= '0;
    end else if (ce && do_wr) begin
      if (wa == addr_boot) boot_q <= apply_strb(boot_q, wd_in_q, ws_q);
      if (wa == addr_wd) wd_q <= apply_strb(wd_q, wd_in_q, ws_q);
      if (wa == addr_fast_clk) fclk_q <= apply_strb(fclk_q, wd_in_q, ws_q);
      if (wa == addr_usm_prc) prc_q <= apply_strb(prc_q, wd_in_q, ws_q);
      if (wa == addr_control) ctl_q <= 6'(apply_strb({26'd0, ctl_q}, wd_in_q, ws_q));
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_cs
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          cs_q[g] <= zero_word;
          comp_q[g] <= zero_word;
        end else if (ce && do_wr) begin
          if (wa == addr_cs0 + 12'(g)) cs_q[g] <= apply_strb(cs_q[g], wd_in_q, ws_q);
          if (is_mapped(wa) && wa >= addr_computed && cidx == 4'(g)) begin
            comp_q[g] <= apply_strb(comp_q[g], wd_in_q, ws_q);
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Firmware event inputs, synchronised
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctl_s1_q <= '0;
      ctl_s2_q <= '0;
      start_q <= 1'b0;
    end else if (ce) begin
      ctl_s1_q <= ctl_q;
      ctl_s2_q <= ctl_s1_q;
      start_q <= ctl_s2_q[ctl_start];
    end
  end

  hour_tick #(.period(hour_period)) u_hour (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .tick(hour_tick_w)
  );

  // ----------------------------------------
  // Decoded outputs
  // ----------------------------------------
  logic fw_present;
  logic thr_active;
  assign fw_present = ctl_s2_q[ctl_fw_present];
  assign thr_active = cfg_q[bit_thr_lo +: 2] != thr_fixed;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl <= '0;
    end else if (ce) begin
      ctrl.table_start <= {1'b1, cfg_q[7:0]}; // R5
      ctrl.table_exponent <= cfg_q[13:8]; // R6
      ctrl.piecewise_cal_enable <= cfg_q[bit_pwl_en]; // R7
      ctrl.vendor_cal_enable <= !cfg_q[bit_vendor_off]; // R7
      ctrl.overflow_keep_value <= cfg_q[bit_keep];
      ctrl.zero_state_allowed <= cfg_q[bit_zero_ind] || !thr_active ||
        !ctl_s2_q[ctl_thr_bad]; // R9
      ctrl.iir_smoothing_enable <= cfg_q[bit_iir]; // R10
      ctrl.recall_enforce <= !cfg_q[bit_no_enf]; // R11
      ctrl.pulse_flow_error <= !cfg_q[bit_pi_supp] && ctl_s2_q[ctl_over_flow]; // R13
      ctrl.pulse_hw_error <= !cfg_q[bit_pi_supp] && cfg_q[bit_pi_hw] &&
        ctl_s2_q[ctl_no_water]; // R13
      ctrl.average_error_counters_on <= cfg_q[bit_err_cnt]; // R14
      ctrl.threshold_regulation_method <= threshold_method_t'(cfg_q[bit_thr_lo +: 2]); // R15
      ctrl.threshold_as_ratio <= cfg_q[bit_ratio]; // R16
      ctrl.sound_speed_limit_check <= cfg_q[bit_vlim]; // R17
      ctrl.volume_triple_protect <= cfg_q[bit_vol]; // R18
      ctrl.cal_temperature_source <= cfg_q[bit_tsens]; // R19
    end
  end

  logic cs_bad;
  always_comb begin
    cs_bad = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (cs_q[i] != comp_q[i]) cs_bad = 1'b1; // R22
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status <= '0;
    end else if (ce) begin
      status.boot_start <= start_q ? (boot_q == boot_activate_code) : status.boot_start; // R1
      status.watchdog_enable <= fw_present || wd_q != wd_disable_code; // R2 R3
      status.config_restore <= fw_present && wd_q != restore_off_code; // R3
      status.force_hourly_timer <= 1'b1; // R4
      status.hourly_recall <= hour_tick_w; // R4
      status.recall_init_pulse <= recall_init; // R12
      status.flow_error <= ctl_s2_q[ctl_over_flow]; // R8
      status.flow_force_zero <= ctl_s2_q[ctl_over_flow] && !cfg_q[bit_keep]; // R8
      status.checksum_error <= cs_bad; // R22
      status.volume_error <= cfg_q[bit_vol] && ctl_s2_q[ctl_no_water] &&
        ctl_s2_q[ctl_recall_done]; // R18
      status.flight_time_rate <= prc_q[31:24]; // R20
      status.rate_error <= prc_q[31:24] == 8'h00; // R20
      status.fast_clock_hz <= (fclk_q == zero_word) ? fast_clk_default : fclk_q; // R21
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  logic [11:0] ra;
  logic [31:0] rd;
  assign ra = s_axi_araddr >> 2; // R23
  always_comb begin
    rd = zero_word;
    case (ra)
      addr_fw_config: rd = cfg_q;
      addr_boot: rd = boot_q;
      addr_wd: rd = wd_q;
      addr_fast_clk: rd = fclk_q;
      addr_usm_prc: rd = prc_q;
      addr_status: rd = {17'd0, status.boot_start, status.watchdog_enable,
        status.config_restore, status.force_hourly_timer, status.flow_force_zero,
        status.flow_error, status.checksum_error, status.volume_error,
        status.rate_error, 6'd0};
      addr_control: rd = {26'd0, ctl_q};
      default: begin
        if (is_cs(ra)) rd = cs_q[ra[1:0]];
        else if (is_mapped(ra)) rd = comp_q[ra[1:0] - 2'd2];
        else rd = zero_word;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'b00;
    end else if (ce) begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd;
        s_axi_rresp <= is_mapped(ra) ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : fw_config_bank

// [hw/fw_config_pkg.sv]
// What this block does
// R1: Activation code at start-up starts bootloading
// R2: Without flow firmware, disable code stops watchdog
// R3: With firmware watchdog on; zero code skips restore
// R4: Force hourly checksum timer and hourly recall
// R5: Bits 7:0 table start, address bit 8 set
// R6: Bits 13:8 exponent scales table coefficients
// R7: Bit 15 piecewise on, bit 31 disables vendor
// R8: Over twice max flow: error, zero unless bit16
// R9: Bit 17 chooses zero-flow versus regulation gating
// R10: Bit 18 enables smoothing filter
// R11: Bit 19 clear enforces legal recall intervals
// R12: Recall init request cleared, done bit set
// R13: Bit 21 suppresses pulse errors, bit 22 widens
// R14: Bit 23 activates average error counters
// R15: Bits 25:24 select threshold regulation method
// R16: Bit 26 threshold as ratio of amplitude
// R17: Bit 27 enables sound speed limit check
// R18: Bit 29 triple volume copies, error if differ; block raises it from bit 29 with no-water and recall-done inputs
// R19: Bit 30 selects calibration temperature source
// R20: Rate from process config top byte, nonzero
// R21: Fast clock frequency, zero means 4 MHz
// R22: Stored checksum mismatch raises checksum error
// R23: Cell address is cell number plus base
package fw_config_pkg;
  localparam logic [11:0] cell_base = 12'h100;
  localparam logic [6:0] cell_fw_config = 7'h6A;
  localparam logic [6:0] cell_boot = 7'h6B;
  localparam logic [6:0] cell_wd = 7'h6C;
  localparam logic [6:0] cell_fast_clk = 7'h66;
  localparam logic [6:0] cell_usm_prc = 7'h74;
  localparam logic [6:0] cell_cs_first = 7'h7C;
  localparam logic [6:0] cell_cs_last = 7'h7F;
  localparam logic [11:0] addr_fw_config = 12'h16A;
  localparam logic [11:0] addr_boot = 12'h16B;
  localparam logic [11:0] addr_wd = 12'h16C;
  localparam logic [11:0] addr_fast_clk = 12'h166;
  localparam logic [11:0] addr_usm_prc = 12'h174;
  localparam logic [11:0] addr_cs0 = 12'h17C;
  localparam logic [11:0] addr_cs1 = 12'h17D;
  localparam logic [11:0] addr_cs2 = 12'h17E;
  localparam logic [11:0] addr_cs3 = 12'h17F;
  localparam logic [11:0] addr_status = 12'h180;
  localparam logic [11:0] addr_control = 12'h181;
  localparam logic [11:0] addr_computed = 12'h182;
  localparam logic [11:0] addr_events = 12'h183;
  localparam logic [31:0] fw_config_reset = 32'h0000_0102;
  localparam logic [31:0] boot_activate_code = 32'hABCD_7654;
  localparam logic [31:0] wd_disable_code = 32'h48DB_A399;
  localparam logic [31:0] restore_off_code = 32'h0000_0000;
  localparam logic [31:0] fast_clk_default = 32'h003D_0900;
  localparam logic [31:0] zero_word = 32'h0000_0000;
  localparam int bit_pwl_en = 15;
  localparam int bit_keep = 16;
  localparam int bit_zero_ind = 17;
  localparam int bit_iir = 18;
  localparam int bit_no_enf = 19;
  localparam int bit_init_done = 20;
  localparam int bit_pi_supp = 21;
  localparam int bit_pi_hw = 22;
  localparam int bit_err_cnt = 23;
  localparam int bit_thr_lo = 24;
  localparam int bit_ratio = 26;
  localparam int bit_vlim = 27;
  localparam int bit_init_req = 28;
  localparam int bit_vol = 29;
  localparam int bit_tsens = 30;
  localparam int bit_vendor_off = 31;
  localparam int ctl_fw_present = 0;
  localparam int ctl_recall_done = 1;
  localparam int ctl_over_flow = 2;
  localparam int ctl_thr_bad = 3;
  localparam int ctl_no_water = 4;
  localparam int ctl_start = 5;
  localparam real clk_mhz = 250.0;
  localparam int hour_s = 3600;
  localparam longint hour_cycles = longint'(hour_s) * 64'd250_000_000;
  typedef enum logic [1:0] {
    thr_fixed = 2'b00,
    thr_trusted = 2'b01,
    thr_trusted_offset = 2'b10,
    thr_special = 2'b11
  } threshold_method_t;
  typedef struct packed {
    logic [8:0] table_start;
    logic [5:0] table_exponent;
    logic piecewise_cal_enable;
    logic vendor_cal_enable;
    logic overflow_keep_value;
    logic zero_state_allowed;
    logic iir_smoothing_enable;
    logic recall_enforce;
    logic pulse_flow_error;
    logic pulse_hw_error;
    logic average_error_counters_on;
    threshold_method_t threshold_regulation_method;
    logic threshold_as_ratio;
    logic sound_speed_limit_check;
    logic volume_triple_protect;
    logic cal_temperature_source;
  } fw_ctrl_t;
  typedef struct packed {
    logic boot_start;
    logic watchdog_enable;
    logic config_restore;
    logic force_hourly_timer;
    logic hourly_recall;
    logic recall_init_pulse;
    logic flow_force_zero;
    logic flow_error;
    logic checksum_error;
    logic volume_error;
    logic rate_error;
    logic [7:0] flight_time_rate;
    logic [31:0] fast_clock_hz;
  } fw_status_t;
endpackage : fw_config_pkg

// [hw/hour_tick.sv]
`timescale 1ns/1ps
module hour_tick #(
  parameter longint period = 64'd900_000_000_000
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  output logic tick
);
  import fw_config_pkg::*;
  logic [39:0] cnt_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      if (cnt_q == 40'(period - 1)) begin
        cnt_q <= '0;
        tick <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 40'd1;
        tick <= 1'b0;
      end
    end
  end
endmodule : hour_tick
